// ==== hdl/pfm_deglitch.sv ====
// Deglitch filter: output rises once the input has stood high for CYCLES.
// Assumes the input is synchronous to aclk.
`timescale 1ns/100ps
`default_nettype none
module pfm_deglitch #(
   parameter int unsigned CYCLES = 640
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic level,
   output logic hit
);
   localparam logic [15:0] CYC16 = 16'(CYCLES);
   logic [15:0] cnt;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cnt <= 16'h0000;
      end else if (!level) begin
         cnt <= 16'h0000;
      end else if (cnt != CYC16) begin
         cnt <= cnt + 16'h0001;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         hit <= 1'b0;
      end else begin
         hit <= level && (cnt == CYC16);
      end
   end
endmodule
`default_nettype wire

// ==== hdl/pfm_good_timer.sv ====
// Power-good one-shot: low at once on a fault, high DELAY cycles after
// the rail is back.
// Assumes the input is synchronous to aclk.
`timescale 1ns/100ps
`default_nettype none
module pfm_good_timer #(
   parameter int unsigned DELAY = 20000
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic below,
   output logic good
);
   localparam logic [15:0] DLY16 = 16'(DELAY);
   logic [15:0] cnt;

   // Any dip restarts the count, so the delay runs from the last rise
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cnt <= 16'h0000;
      end else if (below) begin
         cnt <= 16'h0000;
      end else if (cnt != DLY16) begin
         cnt <= cnt + 16'h0001;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         good <= 1'b0;
      end else begin
         good <= !below && (cnt == DLY16);
      end
   end
endmodule
`default_nettype wire

// ==== hdl/pfm_top.sv ====
// Fault supervisor: latches fault flags, drives the fault interrupt,
// power-good outputs and switch or regulator actions.
// Assumes detector inputs synchronous to aclk and an AXI4-Lite master.
//
// What this block does
// - 12 V input undervoltage opens 12 V switch
// - 5 V input undervoltage opens 5 V switch
// - 12 V clamping sets flag, keeps switches closed
// - 5 V clamping sets flag, keeps switches closed
// - 12 V current limit filtered, flagged, kept on
// - 5 V current limit filtered, flagged, kept on
// - Low rail under 90% drops its good
// - Mid rail under 90% drops its good
// - Low rail short runs hiccup, drops good
// - Mid rail short runs hiccup, drops good
// - Rail overcurrent after 32 us limits, flags
// - 5 V heat warning flags only
// - 12 V heat warning flags only
// - Overheat opens only that switch, flagged
// - Interrupt low until host clears all unmasked flags
// - Good rises only after 1 ms timer
`timescale 1ns/100ps
`default_nettype none
`include "pfm_cfg.svh"
module pfm_top import pfm_pkg::*; #(
   parameter int unsigned OC_FILTER_CYCLES = `PFM_CYCLES_UP(`PFM_OC_FILTER_NS),
   parameter int unsigned PG_DELAY_CYCLES = `PFM_CYCLES_UP(`PFM_PG_DELAY_NS)
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic in12_uvlo,
   input wire logic in5_uvlo,
   input wire logic sw12_clamping,
   input wire logic sw5_clamping,
   input wire logic sw12_ilim,
   input wire logic sw5_ilim,
   input wire logic low_rail_below90,
   input wire logic mid_rail_below90,
   input wire logic low_rail_below70,
   input wire logic mid_rail_below70,
   input wire logic low_rail_ilim,
   input wire logic mid_rail_ilim,
   input wire logic sw5_warm,
   input wire logic sw12_warm,
   input wire logic sw5_hot,
   input wire logic sw12_hot,
   output logic sw12_close,
   output logic sw5_close,
   output logic sw12_clamp,
   output logic sw5_clamp,
   output logic sw12_limit,
   output logic sw5_limit,
   output logic low_rail_recovery,
   output logic mid_rail_recovery,
   output logic low_rail_hiccup,
   output logic mid_rail_hiccup,
   output logic low_rail_limit,
   output logic mid_rail_limit,
   output logic good_low_rail,
   output logic good_mid_rail,
   output logic fault_irq_n
);
   localparam int unsigned SLOW_CYCLES = `PFM_CYCLES_UP(`PFM_SLOW_FILTER_NS);

   pfm_flags_t status, mask, live, set_vec, clr_vec;
   logic [1:0] oc_in, oc_hit;
   logic [3:0] slow_in, slow_hit;
   logic low_short, mid_short, sw12_latched, sw5_latched;
   logic aw_got, w_got;
   logic [7:0] waddr;
   logic [31:0] wdata, wbits;

   // ----------------------------------------
   // Event filters
   // ----------------------------------------
   assign oc_in = {sw5_ilim, sw12_ilim};
   assign slow_in = {sw12_warm, sw5_warm, mid_rail_ilim, low_rail_ilim};
   genvar gi;
   generate
      for (gi = 0; gi < 2; gi++) begin : g_oc
         pfm_deglitch #(.CYCLES(OC_FILTER_CYCLES)) u_flt (
            .aclk(aclk), .aresetn(aresetn), .level(oc_in[gi]), .hit(oc_hit[gi]));
      end
      for (gi = 0; gi < 4; gi++) begin : g_slow
         pfm_deglitch #(.CYCLES(SLOW_CYCLES)) u_flt (
            .aclk(aclk), .aresetn(aresetn), .level(slow_in[gi]), .hit(slow_hit[gi]));
      end
   endgenerate

   assign low_short = low_rail_below70 && low_rail_ilim;
   assign mid_short = mid_rail_below70 && mid_rail_ilim;

   // ----------------------------------------
   // Flag sources
   // ----------------------------------------
   always_comb begin
      live = `PFM_STATUS_RESET;
      live[`PFM_B_IN12_UNDER] = in12_uvlo;
      live[`PFM_B_IN5_UNDER] = in5_uvlo;
      live[`PFM_B_IN12_OVER] = sw12_clamping;
      live[`PFM_B_IN5_OVER] = sw5_clamping;
      live[`PFM_B_SW12_OC] = oc_hit[0];
      live[`PFM_B_SW5_OC] = oc_hit[1];
      live[`PFM_B_LOW_UNDER] = low_rail_below90 || low_short;
      live[`PFM_B_MID_UNDER] = mid_rail_below90 || mid_short;
      live[`PFM_B_LOW_OC] = slow_hit[0];
      live[`PFM_B_MID_OC] = slow_hit[1];
      live[`PFM_B_SW5_WARN] = slow_hit[2];
      live[`PFM_B_SW12_WARN] = slow_hit[3];
      live[`PFM_B_SW5_HOT] = sw5_hot;
      live[`PFM_B_SW12_HOT] = sw12_hot;
   end
   assign set_vec = live;

   // ----------------------------------------
   // Register bus
   // ----------------------------------------
   // Byte lanes the master did not strobe are written as zeros
   assign wbits = wdata;
   assign clr_vec = (aw_got && w_got && !s_axi_bvalid && waddr == `PFM_ADDR_STATUS) ?
                    wbits[`PFM_NFLAGS-1:0] : `PFM_STATUS_RESET;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_awready <= 1'b0;
         aw_got <= 1'b0;
         waddr <= 8'h00;
      end else if (s_axi_awvalid && s_axi_awready) begin
         s_axi_awready <= 1'b0;
         aw_got <= 1'b1;
         waddr <= s_axi_awaddr;
      end else if (s_axi_bvalid && s_axi_bready) begin
         s_axi_awready <= 1'b1;
         aw_got <= 1'b0;
      end else if (!aw_got && !s_axi_bvalid) begin
         s_axi_awready <= 1'b1;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_wready <= 1'b0;
         w_got <= 1'b0;
         wdata <= 32'h0000_0000;
      end else if (s_axi_wvalid && s_axi_wready) begin
         s_axi_wready <= 1'b0;
         w_got <= 1'b1;
         wdata <= s_axi_wdata & {{8{s_axi_wstrb[3]}}, {8{s_axi_wstrb[2]}},
                                 {8{s_axi_wstrb[1]}}, {8{s_axi_wstrb[0]}}};
      end else if (s_axi_bvalid && s_axi_bready) begin
         s_axi_wready <= 1'b1;
         w_got <= 1'b0;
      end else if (!w_got && !s_axi_bvalid) begin
         s_axi_wready <= 1'b1;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= PFM_OKAY;
      end else if (aw_got && w_got && !s_axi_bvalid) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp <= (waddr == `PFM_ADDR_STATUS || waddr == `PFM_ADDR_MASK) ? PFM_OKAY : PFM_SLVERR;
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         mask <= `PFM_MASK_RESET;
      end else if (aw_got && w_got && !s_axi_bvalid && waddr == `PFM_ADDR_MASK) begin
         mask <= wbits[`PFM_NFLAGS-1:0];
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= PFM_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b1;
         s_axi_rresp <= PFM_OKAY;
         case (s_axi_araddr)
            `PFM_ADDR_STATUS: s_axi_rdata <= {18'h00000, status};
            `PFM_ADDR_MASK: s_axi_rdata <= {18'h00000, mask};
            `PFM_ADDR_LIVE: s_axi_rdata <= {18'h00000, live};
            default: begin
               s_axi_rdata <= 32'h0000_0000;
               s_axi_rresp <= PFM_SLVERR;
            end
         endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
         s_axi_arready <= 1'b1;
      end else if (!s_axi_rvalid) begin
         s_axi_arready <= 1'b1;
      end
   end

   // ----------------------------------------
   // Sticky flags and interrupt
   // ----------------------------------------
   // Each flag sets on its own, so a frequent rail overcurrent never
   // blocks another fault from being recorded; set wins over clear.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         status <= `PFM_STATUS_RESET;
      end else begin
         status <= (status & ~clr_vec) | set_vec;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         fault_irq_n <= 1'b1;
      end else begin
         fault_irq_n <= ~|(status & ~mask);
      end
   end

   // ----------------------------------------
   // Switch and regulator actions
   // ----------------------------------------
   // Overheat latches the switch open until reset; the other switch is untouched
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         sw12_latched <= 1'b0;
         sw5_latched <= 1'b0;
      end else begin
         sw12_latched <= sw12_latched || sw12_hot;
         sw5_latched <= sw5_latched || sw5_hot;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         sw12_close <= 1'b0;
         sw5_close <= 1'b0;
      end else begin
         sw12_close <= !(in12_uvlo || sw12_hot || sw12_latched);
         sw5_close <= !(in5_uvlo || sw5_hot || sw5_latched);
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         sw12_clamp <= 1'b0;
         sw5_clamp <= 1'b0;
         sw12_limit <= 1'b0;
         sw5_limit <= 1'b0;
      end else begin
         sw12_clamp <= sw12_clamping;
         sw5_clamp <= sw5_clamping;
         sw12_limit <= oc_hit[0];
         sw5_limit <= oc_hit[1];
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         low_rail_recovery <= 1'b0;
         mid_rail_recovery <= 1'b0;
         low_rail_hiccup <= 1'b0;
         mid_rail_hiccup <= 1'b0;
         low_rail_limit <= 1'b0;
         mid_rail_limit <= 1'b0;
      end else begin
         low_rail_recovery <= low_rail_below90 && !low_short;
         mid_rail_recovery <= mid_rail_below90 && !mid_short;
         low_rail_hiccup <= low_short;
         mid_rail_hiccup <= mid_short;
         low_rail_limit <= slow_hit[0];
         mid_rail_limit <= slow_hit[1];
      end
   end

   pfm_good_timer #(.DELAY(PG_DELAY_CYCLES)) u_good_low (
      .aclk(aclk), .aresetn(aresetn), .below(live[`PFM_B_LOW_UNDER]), .good(good_low_rail));
   pfm_good_timer #(.DELAY(PG_DELAY_CYCLES)) u_good_mid (
      .aclk(aclk), .aresetn(aresetn), .below(live[`PFM_B_MID_UNDER]), .good(good_mid_rail));

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   a_flag_in12_under_open_only: assert property (in12_uvlo && !in5_uvlo && !sw5_hot && !sw5_latched
      |=> !sw12_close && sw5_close && status[`PFM_B_IN12_UNDER]) else $error("12 V undervoltage action wrong");
   a_uv5_open_only: assert property (in5_uvlo && !in12_uvlo && !sw12_hot && !sw12_latched
      |=> !sw5_close && sw12_close && status[`PFM_B_IN5_UNDER]) else $error("5 V undervoltage action wrong");
   a_clamp_flags: assert property (sw12_clamping |=> sw12_clamp && status[`PFM_B_IN12_OVER])
      else $error("12 V clamp not flagged");
   a_clamp5_flags: assert property (sw5_clamping |=> sw5_clamp && status[`PFM_B_IN5_OVER])
      else $error("5 V clamp not flagged");
   a_oc_filter_wait: assert property ($rose(sw12_ilim) |-> !sw12_limit[*8]) else $error("12 V limit early");
   a_oc5_flag: assert property ($rose(oc_hit[1]) |=> sw5_limit && status[`PFM_B_SW5_OC])
      else $error("5 V overcurrent not flagged");
   a_low_good_drop: assert property (low_rail_below90 |=> ##1 !good_low_rail) else $error("low good high");
   a_mid_good_drop: assert property (mid_rail_below90 |=> ##1 !good_mid_rail) else $error("mid good high");
   a_low_short: assert property (low_short
      |=> low_rail_hiccup && !low_rail_recovery && status[`PFM_B_LOW_UNDER]) else $error("low short missed");
   a_mid_short: assert property (mid_short |=> mid_rail_hiccup && status[`PFM_B_MID_UNDER])
      else $error("mid rail short not handled");
   a_rail_oc_limit: assert property ($rose(slow_hit[1]) |=> mid_rail_limit && status[`PFM_B_MID_OC])
      else $error("mid rail overcurrent not flagged");
   a_warn_no_action: assert property ($rose(slow_hit[2]) && !in5_uvlo && !sw5_hot && !sw5_latched
      |=> status[`PFM_B_SW5_WARN] && sw5_close) else $error("5 V warning wrong");
   a_warn12_flag: assert property ($rose(slow_hit[3]) |=> status[`PFM_B_SW12_WARN])
      else $error("12 V warning lost");
   a_hot_latch: assert property (sw12_hot |=> !sw12_close [*4]) else $error("12 V switch not held open");
   a_irq_hold: assert property (|(status & ~mask) |=> !fault_irq_n) else $error("interrupt not held low");
   a_good_delay: assert property ($rose(good_low_rail) |-> !$past(low_rail_below90, 2))
      else $error("good rose early");
   c_flag_in12_under_seen: cover property (in12_uvlo ##1 !sw12_close);
   c_short_seen: cover property (low_short ##1 low_rail_hiccup);
   c_irq_cleared: cover property (!fault_irq_n ##[1:50] fault_irq_n);
   c_good_back: cover property ($rose(good_mid_rail));
endmodule
`default_nettype wire

// ==== include/pfm_cfg.svh ====
// Constants of the power fault manager: offsets, field positions,
// reset values and timing figures.
// Assumes a single 20 MHz clock; included by bare name.
`ifndef PFM_CFG_SVH
`define PFM_CFG_SVH
// ----------------------------------------
// Timing
// ----------------------------------------
`define PFM_CLK_NS 50
`define PFM_OC_FILTER_NS 1024000
`define PFM_SLOW_FILTER_NS 32000
`define PFM_PG_DELAY_NS 1000000
`define PFM_CYCLES_UP(ns) (((ns) + `PFM_CLK_NS - 1) / `PFM_CLK_NS)
// ----------------------------------------
// Register offsets and reset values
// ----------------------------------------
`define PFM_ADDR_STATUS 8'h00
`define PFM_ADDR_MASK 8'h04
`define PFM_ADDR_LIVE 8'h08
`define PFM_STATUS_RESET 14'h0000
`define PFM_MASK_RESET 14'h0000
`define PFM_NFLAGS 14
// ----------------------------------------
// Flag positions
// ----------------------------------------
`define PFM_B_IN12_UNDER 0
`define PFM_B_IN5_UNDER 1
`define PFM_B_IN12_OVER 2
`define PFM_B_IN5_OVER 3
`define PFM_B_SW12_OC 4
`define PFM_B_SW5_OC 5
`define PFM_B_LOW_UNDER 6
`define PFM_B_MID_UNDER 7
`define PFM_B_LOW_OC 8
`define PFM_B_MID_OC 9
`define PFM_B_SW5_WARN 10
`define PFM_B_SW12_WARN 11
`define PFM_B_SW5_HOT 12
`define PFM_B_SW12_HOT 13
`endif

// ==== include/pfm_pkg.sv ====
// Types shared by the power fault manager files.
// Assumes pfm_cfg.svh is on the include path.
`include "pfm_cfg.svh"
package pfm_pkg;
   typedef logic [`PFM_NFLAGS-1:0] pfm_flags_t;
   typedef enum logic [1:0] {PFM_OKAY = 2'h0, PFM_SLVERR = 2'h2} pfm_resp_t;
endpackage

// ==== test/pfm_host_model.sv ====
// Host model: AXI4-Lite master that reads and clears fault flags.
// Assumes the bench calls wr and rd one at a time from one process.
`timescale 1ns/100ps
`default_nettype none
module pfm_host_model (
   input wire logic aclk,
   output logic [7:0] s_axi_awaddr,
   output logic s_axi_awvalid,
   input wire logic s_axi_awready,
   output logic [31:0] s_axi_wdata,
   output logic [3:0] s_axi_wstrb,
   output logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_bvalid,
   output logic s_axi_bready,
   output logic [7:0] s_axi_araddr,
   output logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0] s_axi_rresp,
   input wire logic s_axi_rvalid,
   output logic s_axi_rready
);
   initial begin
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
      s_axi_wstrb = 4'hf;
   end
   // ----------------------------------------
   // Bus cycles
   // ----------------------------------------
   // Released payloads are inverted so a stale value never looks valid
   task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(posedge aclk);
         if (s_axi_awvalid && s_axi_awready) {s_axi_awvalid, s_axi_awaddr} <= {1'b0, ~a};
         if (s_axi_wvalid && s_axi_wready) {s_axi_wvalid, s_axi_wdata} <= {1'b0, ~d};
      end while (s_axi_bvalid !== 1'b1);
      r = s_axi_bresp;
      s_axi_bready <= 1'b0;
   endtask
   task automatic set_strobe(input logic [3:0] s);
      @(posedge aclk);
      s_axi_wstrb <= s;
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
         @(posedge aclk);
         if (s_axi_arvalid && s_axi_arready) {s_axi_arvalid, s_axi_araddr} <= {1'b0, ~a};
      end while (s_axi_rvalid !== 1'b1);
      d = s_axi_rdata;
      r = s_axi_rresp;
      s_axi_rready <= 1'b0;
   endtask
endmodule
`default_nettype wire

// ==== test/pfm_top_tb_top.sv ====
// Testbench of the fault supervisor: detector events, flags, interrupt.
// Assumes short filter and good-timer parameters; host model drives AXI.
`timescale 1ns/100ps
`default_nettype none
`include "pfm_cfg.svh"
module pfm_top_tb_top import pfm_pkg::*;;
   localparam int OCF = 8;
   localparam int PGD = 10;
   localparam logic [7:0] ST = `PFM_ADDR_STATUS;
   localparam logic [7:0] MK = `PFM_ADDR_MASK;
   localparam logic [7:0] LV = `PFM_ADDR_LIVE;
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   logic [15:0] flt = 16'h0000;
   logic [7:0] s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata, dat;
   logic [3:0] s_axi_wstrb;
   logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
   logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
   logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
   logic sw12_close, sw5_close, sw12_clamp, sw5_clamp, sw12_limit, sw5_limit;
   logic low_rail_recovery, mid_rail_recovery, low_rail_hiccup, mid_rail_hiccup;
   logic low_rail_limit, mid_rail_limit, good_low_rail, good_mid_rail, fault_irq_n;
   int fails = 0;
   int total_checks = 0;
   always #25 aclk = ~aclk;
   pfm_top #(.OC_FILTER_CYCLES(OCF), .PG_DELAY_CYCLES(PGD)) u_pfm_top (
      .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
      .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
      .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
      .s_axi_rvalid, .s_axi_rready, .in12_uvlo(flt[0]), .in5_uvlo(flt[1]),
      .sw12_clamping(flt[2]), .sw5_clamping(flt[3]), .sw12_ilim(flt[4]), .sw5_ilim(flt[5]),
      .low_rail_below90(flt[6]), .mid_rail_below90(flt[7]), .low_rail_below70(flt[8]),
      .mid_rail_below70(flt[9]), .low_rail_ilim(flt[10]), .mid_rail_ilim(flt[11]),
      .sw5_warm(flt[12]), .sw12_warm(flt[13]), .sw5_hot(flt[14]), .sw12_hot(flt[15]),
      .sw12_close, .sw5_close, .sw12_clamp, .sw5_clamp, .sw12_limit, .sw5_limit,
      .low_rail_recovery, .mid_rail_recovery, .low_rail_hiccup, .mid_rail_hiccup,
      .low_rail_limit, .mid_rail_limit, .good_low_rail, .good_mid_rail, .fault_irq_n);
   pfm_host_model u_pfm_host_model (
      .aclk, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
      .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
      .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
      .s_axi_rvalid, .s_axi_rready);
   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   task automatic chk(input logic ok, input string m);
      total_checks++;
      if (ok !== 1'b1) begin
         fails++;
         $display("[ERR] %0t %s", $time, m);
      end
   endtask
   task automatic tally_and_finish;
      if (fails == 0 && total_checks > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   task automatic wx(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r, input string m);
      u_pfm_host_model.wr(a, d, rsp);
      chk(rsp === r, m);
   endtask
   task automatic rx(input logic [7:0] a, input logic [31:0] e, input logic [1:0] r, input string m);
      u_pfm_host_model.rd(a, dat, rsp);
      chk(dat === e && rsp === r, m);
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge aclk);
   endtask
   // Switch opened by overheat stays open until reset, hence a full reset
   task automatic do_reset;
      aresetn <= 1'b0;
      flt <= 16'h0000;
      cyc(20);
      aresetn <= 1'b1;
      cyc(2);
      chk(fault_irq_n === 1'b1 && good_low_rail === 1'b0, "reset outputs");
      cyc(PGD + 4);
      chk({sw12_close, sw5_close, good_low_rail, good_mid_rail} === 4'hf, "after reset");
      rx(ST, 32'h0, PFM_OKAY, "status reset");
      rx(MK, 32'h0, PFM_OKAY, "mask reset");
   endtask
   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   // Holds an event past every filter, checks actions and flags, clears
   task automatic ev(input logic [15:0] s, input logic [13:0] f, input logic [13:0] o, input string m);
      flt <= s;
      cyc(700);
      chk({sw12_close, sw5_close, good_low_rail, good_mid_rail, sw12_clamp, sw5_clamp,
           sw12_limit, sw5_limit, low_rail_recovery, mid_rail_recovery, low_rail_hiccup,
           mid_rail_hiccup, low_rail_limit, mid_rail_limit} === o && fault_irq_n === 1'b0, m);
      rx(ST, {18'h0, f}, PFM_OKAY, m);
      flt <= 16'h0000;
      cyc(PGD + 6);
      wx(ST, 32'h0000_3fff, PFM_OKAY, m);
      rx(ST, 32'h0, PFM_OKAY, m);
      chk(fault_irq_n === 1'b1, m);
   endtask
   task automatic t_regs;
      wx(MK, 32'hffff_ffff, PFM_OKAY, "mask wr");
      rx(MK, 32'h0000_3fff, PFM_OKAY, "mask rd");
      u_pfm_host_model.set_strobe(4'h1);
      wx(MK, 32'hffff_ffff, PFM_OKAY, "mask lane");
      rx(MK, 32'h0000_00ff, PFM_OKAY, "mask lane rd");
      u_pfm_host_model.set_strobe(4'hf);
      wx(8'h0c, 32'h0000_0001, PFM_SLVERR, "unmapped wr");
      rx(8'h0c, 32'h0, PFM_SLVERR, "unmapped rd");
      wx(LV, 32'h0000_0001, PFM_SLVERR, "live wr");
      wx(MK, 32'h0000_0001, PFM_OKAY, "mask one");
   endtask
   task automatic t_irq;
      flt <= 16'h0001;
      cyc(6);
      chk(fault_irq_n === 1'b1, "masked irq");
      rx(LV, 32'h1, PFM_OKAY, "live");
      wx(ST, 32'h1, PFM_OKAY, "clr held");
      rx(ST, 32'h1, PFM_OKAY, "held flag re-sets");
      flt <= 16'h0002;
      wx(MK, 32'h0, PFM_OKAY, "unmask");
      cyc(3);
      flt <= 16'h0000;
      cyc(3);
      wx(ST, 32'h1, PFM_OKAY, "clr one");
      cyc(2);
      chk(fault_irq_n === 1'b0, "irq held by other flag");
      wx(ST, 32'h2, PFM_OKAY, "clr two");
      cyc(2);
      chk(fault_irq_n === 1'b1, "irq released");
   endtask
   // Pulses shorter than the filters must leave no flag
   task automatic t_short;
      flt <= 16'h0010;
      cyc(OCF - 3);
      flt <= 16'h0400;
      cyc(630);
      flt <= 16'h0000;
      cyc(4);
      rx(ST, 32'h0, PFM_OKAY, "short pulses");
      chk(fault_irq_n === 1'b1, "short irq");
   endtask
   task automatic t_good;
      flt <= 16'h0040;
      cyc(10);
      flt <= 16'h0000;
      cyc(PGD + 1);
      chk(good_low_rail === 1'b0, "good early");
      cyc(1);
      chk(good_low_rail === 1'b1, "good late");
      wx(ST, 32'h0000_3fff, PFM_OKAY, "good clr");
   endtask
   initial begin
      cyc(60000);
      fails++;
      tally_and_finish();
   end
   initial begin
      do_reset();
      t_regs();
      t_irq();
      t_short();
      t_good();
      ev(16'h0001, 14'h0001, 14'h1c00, "in12 under");
      ev(16'h0002, 14'h0002, 14'h2c00, "in5 under");
      ev(16'h0004, 14'h0004, 14'h3e00, "in12 over");
      ev(16'h0008, 14'h0008, 14'h3d00, "in5 over");
      ev(16'h0010, 14'h0010, 14'h3c80, "sw12 oc");
      ev(16'h0020, 14'h0020, 14'h3c40, "sw5 oc");
      ev(16'h0040, 14'h0040, 14'h3420, "low under");
      ev(16'h0080, 14'h0080, 14'h3810, "mid under");
      ev(16'h0500, 14'h0140, 14'h340a, "low short");
      ev(16'h0a00, 14'h0280, 14'h3805, "mid short");
      ev(16'h0400, 14'h0100, 14'h3c02, "low oc");
      ev(16'h0800, 14'h0200, 14'h3c01, "mid oc");
      ev(16'h1000, 14'h0400, 14'h3c00, "sw5 warn");
      ev(16'h2000, 14'h0800, 14'h3c00, "sw12 warn");
      ev(16'h4000, 14'h1000, 14'h2c00, "sw5 hot");
      do_reset();
      ev(16'h8000, 14'h2000, 14'h1c00, "sw12 hot");
      tally_and_finish();
   end
endmodule
`default_nettype wire
